/* core/serial_dma_buffer_regs.sv */
// ahb-lite register block for the serial ping-pong dma buffers and irq enables
`timescale 1ns/1ps
module serial_dma_buffer_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire serial_dma_pkg::rx_event_t rx_event,
    input wire logic [serial_dma_pkg::IRQ_W-1:0] irq_event,
    output serial_dma_pkg::buf_addr_t buf_addr,
    output logic [1:0][serial_dma_pkg::ADDR_W-1:0] rx_err_ofs,
    output logic [1:0] rx_overrun_status,
    output logic irq
);
    import serial_dma_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    logic wr_pend_q;
    logic rd_pend_q;
    logic [29:0] idx_q;
    logic hreadyout_q;
    logic [31:0] hrdata_q;
    logic req;
    logic wr_en;
    logic [15:0] rd_mux;
    buf_addr_t buf_addr_q;
    logic [1:0][ADDR_W-1:0] err_ofs_q;
    logic [1:0] err_cap_q;
    logic [1:0] ovf_q;
    logic [IRQ_W-1:0] enable_q;
    logic [IRQ_W-1:0] pending_q;
    logic [IRQ_W-1:0] w1c;
    logic irq_q;
    logic hresp_q;

    assign req = hsel & htrans[1] & hready;
    assign wr_en = wr_pend_q & hreadyout_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 30'h0000_0000;
        end else if (hready) begin
            wr_pend_q <= req & hwrite;
            rd_pend_q <= req & ~hwrite;
            idx_q <= haddr[31:2];
        end
    end

    // reads take one wait state so that a write just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= ~(req & ~hwrite & hreadyout_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= RDATA_RESET;
        end else if (rd_pend_q & ~hreadyout_q) begin
            hrdata_q <= {16'h0000, rd_mux};
        end
    end

    // unmapped indices read zero and ignore writes
    always_comb begin
        rd_mux = 16'h0000;
        case (idx_q)
            IDX_RX_A_START: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.rx_a_start};
            IDX_RX_A_END: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.rx_a_end};
            IDX_RX_B_START: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.rx_b_start};
            IDX_RX_B_END: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.rx_b_end};
            IDX_TX_A_START: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.tx_a_start};
            IDX_TX_A_END: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.tx_a_end};
            IDX_TX_B_START: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.tx_b_start};
            IDX_TX_B_END: rd_mux = {1'b0, ADDR_TOP_BITS[1:0], buf_addr_q.tx_b_end};
            IDX_RX_A_ERR: rd_mux = {3'h0, err_ofs_q[0]};
            IDX_RX_B_ERR: rd_mux = {3'h0, err_ofs_q[1]};
            IDX_RX_OVF_STAT: rd_mux = {14'h0000, ovf_q};
            IDX_IRQ_PENDING: rd_mux = {1'b0, pending_q};
            IDX_IRQ_ENABLE: rd_mux = {1'b0, enable_q};
            default: rd_mux = 16'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // buffer address registers

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            buf_addr_q <= {8{ADDR_RESET}};
        end else if (wr_en) begin
            case (idx_q)
                IDX_RX_A_START: buf_addr_q.rx_a_start <= hwdata[ADDR_W-1:0];
                IDX_RX_A_END: buf_addr_q.rx_a_end <= hwdata[ADDR_W-1:0];
                IDX_RX_B_START: buf_addr_q.rx_b_start <= hwdata[ADDR_W-1:0];
                IDX_RX_B_END: buf_addr_q.rx_b_end <= hwdata[ADDR_W-1:0];
                IDX_TX_A_START: buf_addr_q.tx_a_start <= hwdata[ADDR_W-1:0];
                IDX_TX_A_END: buf_addr_q.tx_a_end <= hwdata[ADDR_W-1:0];
                IDX_TX_B_START: buf_addr_q.tx_b_start <= hwdata[ADDR_W-1:0];
                IDX_TX_B_END: buf_addr_q.tx_b_end <= hwdata[ADDR_W-1:0];
                default: buf_addr_q <= buf_addr_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-buffer error capture and overrun status

    for (genvar b = 0; b < 2; b++) begin : g_rx_buf
        // an error in the reload cycle is kept: the set wins, even over an older capture
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                err_cap_q[b] <= 1'b0;
                err_ofs_q[b] <= ERR_OFS_RESET;
            end else if (rx_event.error[b] &
                    (~err_cap_q[b] | rx_event.load[b] | rx_event.dma_reset)) begin
                err_cap_q[b] <= 1'b1;
                err_ofs_q[b] <= rx_event.error_ofs;
            end else if (rx_event.load[b] | rx_event.dma_reset) begin
                err_cap_q[b] <= 1'b0;
                err_ofs_q[b] <= ERR_OFS_RESET;
            end
        end

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ovf_q[b] <= 1'b0;
            end else begin
                ovf_q[b] <= rx_event.overrun[b] |
                    (ovf_q[b] & ~(rx_event.load[b] | rx_event.dma_reset));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt enable and pending flags

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= IRQ_RESET;
        end else if (wr_en && idx_q == IDX_IRQ_ENABLE) begin
            enable_q <= hwdata[IRQ_W-1:0];
        end
    end

    // write one to clear; a new event in the same cycle stays pending
    assign w1c = (wr_en && idx_q == IDX_IRQ_PENDING) ? hwdata[IRQ_W-1:0] : IRQ_RESET;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_q <= IRQ_RESET;
        end else begin
            pending_q <= (pending_q & ~w1c) | irq_event;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(pending_q & enable_q);
        end
    end

    // response is always okay; kept in a flop so every output is registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign buf_addr = buf_addr_q;
    assign rx_err_ofs = err_ofs_q;
    assign rx_overrun_status = ovf_q;
    assign irq = irq_q;

endmodule

/* core/serial_dma_pkg.sv */
// constants and types for the serial ping-pong dma register block
//
// Notes on behaviour
// - rx buffer a end address, writable, 13 bits
// - rx buffer b start address, writable, 13 bits
// - rx buffer b end address, writable, 13 bits
// - tx buffer a start address, writable, 13 bits
// - tx buffer a end address, writable, 13 bits
// - tx buffer b start address, writable, 13 bits
// - tx buffer b end address, writable, 13 bits
// - rx a first error offset, read-only, zero if none
// - rx b first error offset, read-only, zero if none
// - captured error offset ignores later errors
// - rearm capture on buffer reload or rx reset
// - enables: parity error bit 14, framing bit 13
// - enables: unloaded tx b12 tx a11 rx b10 a9
// - enables: nack 8, cmd done 7, tx 6, rx 5
// - enables: underrun 4, idle 2, free 1, rxdata 0
// - enable for receive overrun at bit 3
// - pending flags mirror enable bits, bit 15 zero
// - rx buffer a start address, writable, 13 bits
// - per-buffer overrun status clears on load or reset
package serial_dma_pkg;

    localparam int ADDR_W = 13;
    localparam int IRQ_W = 15;

    // register indices; byte address is four times the index
    localparam logic [29:0] IDX_RX_A_START = 30'h0000_4480;
    localparam logic [29:0] IDX_RX_A_END = 30'h0000_4482;
    localparam logic [29:0] IDX_RX_B_START = 30'h0000_4484;
    localparam logic [29:0] IDX_RX_B_END = 30'h0000_4486;
    localparam logic [29:0] IDX_TX_A_START = 30'h0000_4488;
    localparam logic [29:0] IDX_TX_A_END = 30'h0000_448A;
    localparam logic [29:0] IDX_TX_B_START = 30'h0000_448C;
    localparam logic [29:0] IDX_TX_B_END = 30'h0000_448E;
    localparam logic [29:0] IDX_RX_A_ERR = 30'h0000_449A;
    localparam logic [29:0] IDX_RX_B_ERR = 30'h0000_449C;
    localparam logic [29:0] IDX_RX_OVF_STAT = 30'h0000_44A0;
    localparam logic [29:0] IDX_IRQ_PENDING = 30'h0000_460C;
    localparam logic [29:0] IDX_IRQ_ENABLE = 30'h0000_4624;

    // bits 14:13 of every buffer address register read as ones
    localparam logic [2:0] ADDR_TOP_BITS = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] ERR_OFS_RESET = 13'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 15'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // event bit positions, shared by enable and pending registers
    localparam int EV_PARITY = 14;
    localparam int EV_FRAMING = 13;
    localparam int EV_TX_B_UNLOADED = 12;
    localparam int EV_TX_A_UNLOADED = 11;
    localparam int EV_RX_B_UNLOADED = 10;
    localparam int EV_RX_A_UNLOADED = 9;
    localparam int EV_NACK = 8;
    localparam int EV_START_STOP_DONE = 7;
    localparam int EV_TX_OP_DONE = 6;
    localparam int EV_RX_OP_DONE = 5;
    localparam int EV_TX_UNDERRUN = 4;
    localparam int EV_RX_OVERRUN = 3;
    localparam int EV_TX_IDLE = 2;
    localparam int EV_TX_FREE = 1;
    localparam int EV_RX_VALID = 0;

    typedef struct packed {
        logic [ADDR_W-1:0] rx_a_start;
        logic [ADDR_W-1:0] rx_a_end;
        logic [ADDR_W-1:0] rx_b_start;
        logic [ADDR_W-1:0] rx_b_end;
        logic [ADDR_W-1:0] tx_a_start;
        logic [ADDR_W-1:0] tx_a_end;
        logic [ADDR_W-1:0] tx_b_start;
        logic [ADDR_W-1:0] tx_b_end;
    } buf_addr_t;

    // per-buffer receive dma events; index 0 is buffer a, 1 is buffer b
    typedef struct packed {
        logic dma_reset;
        logic [1:0] load;
        logic [1:0] error;
        logic [ADDR_W-1:0] error_ofs;
        logic [1:0] overrun;
    } rx_event_t;

endpackage

/* testbench/serial_dma_buffer_regs_assertions.sv */
// port assertions for the serial dma register block
`timescale 1ns/1ps
module serial_dma_buffer_regs_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire serial_dma_pkg::rx_event_t rx_event,
    input wire serial_dma_pkg::buf_addr_t buf_addr,
    input wire logic [1:0][serial_dma_pkg::ADDR_W-1:0] rx_err_ofs,
    input wire logic [1:0] rx_overrun_status
);
    import serial_dma_pkg::*;
    logic acc;
    assign acc = hsel && htrans[1] && hready;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_rd_wait;
        acc && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast;
        acc && hwrite |=> hreadyout;
    endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_buf_chg;
        $changed(buf_addr) |-> $past(acc && hwrite, 2);
    endproperty
    a_buf_chg: assert property (p_buf_chg) else $error("address moved");
    property p_err_hold;
        rx_err_ofs[0] != '0 && !rx_event.load[0] && !rx_event.dma_reset |=> $stable(rx_err_ofs[0]);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("offset moved");
    property p_err_clr;
        (rx_event.load[0] || rx_event.dma_reset) && !rx_event.error[0] |=> rx_err_ofs[0] == '0;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("offset kept");
    property p_err_cap;
        rx_event.load[1] && !rx_event.error[1] ##1 rx_event.error[1]
            |=> rx_err_ofs[1] == $past(rx_event.error_ofs);
    endproperty
    a_err_cap: assert property (p_err_cap) else $error("offset missed");
    property p_ovf_set;
        rx_event.overrun[1] && !rx_event.load[1] && !rx_event.dma_reset |=> rx_overrun_status[1];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overrun lost");
    property p_ovf_clr;
        (rx_event.load[0] || rx_event.dma_reset) && !rx_event.overrun[0] |=> !rx_overrun_status[0];
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overrun kept");
endmodule

/* testbench/dma_side_model.sv */
// pulse driver standing in for the serial dma engine
`timescale 1ns/1ps
module dma_side_model (
    input wire logic hclk,
    output serial_dma_pkg::rx_event_t rx_event,
    output logic [serial_dma_pkg::IRQ_W-1:0] irq_event
);
    import serial_dma_pkg::*;
    initial begin
        rx_event = '0;
        irq_event = '0;
    end
    // two events in a row, so back-to-back cases need no same-step release
    task automatic rx(input rx_event_t a, input rx_event_t b);
        rx_event <= a;
        @(posedge hclk);
        rx_event <= b;
        @(posedge hclk);
        rx_event <= '0;
    endtask
    task automatic ev(input logic [IRQ_W-1:0] v);
        irq_event <= v;
        @(posedge hclk);
        irq_event <= '0;
    endtask
endmodule

/* testbench/testbench.sv */
// self-checking bench for the serial dma register block
`timescale 1ns/1ps
module testbench;
    import serial_dma_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hresp, irq;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [1:0] rx_overrun_status;
    logic [1:0][ADDR_W-1:0] rx_err_ofs;
    logic [IRQ_W-1:0] irq_event;
    rx_event_t rx_event;
    buf_addr_t buf_addr;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #10 hclk = ~hclk;
    serial_dma_buffer_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .rx_event(rx_event),
        .irq_event(irq_event), .buf_addr(buf_addr), .rx_err_ofs(rx_err_ofs),
        .rx_overrun_status(rx_overrun_status), .irq(irq));
    dma_side_model dma (.hclk(hclk), .rx_event(rx_event), .irq_event(irq_event));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // entered just after a rising edge; waits on hready, bounded by the watchdog
    task automatic bus(input logic [29:0] idx, input logic wr, input logic [31:0] wd);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= {idx, 2'h0};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [29:0] idx, input logic [31:0] e);
        bus(idx, 0, '0);
        chk($sformatf("reg %h", idx), e, rd);
    endtask
    task automatic t_regs;
        logic [ADDR_W-1:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 13'h1A5A + 13'(i);
            rdchk(30'(IDX_RX_A_START + 2 * i), 32'h0000_6000);
            bus(30'(IDX_RX_A_START + 2 * i), 1, {19'h7_FFFF, v});
            rdchk(30'(IDX_RX_A_START + 2 * i), {19'h0_0003, v});
            chk("buf_addr", 32'(v), 32'(buf_addr[103 - ADDR_W * i -: ADDR_W]));
        end
        bus(IDX_RX_A_ERR, 1, 32'h0000_1FFF);
        rdchk(IDX_RX_A_ERR, '0);
        bus(30'h0000_4481, 1, '1);
        rdchk(30'h0000_4481, '0);
        chk("hresp", '0, 32'(hresp));
    endtask
    task automatic t_err;
        dma.rx('{0, 0, 2'h1, 13'h0005, 0}, '{0, 0, 2'h1, 13'h0009, 0});
        rdchk(IDX_RX_A_ERR, 32'h0000_0005);
        chk("rx_err_ofs a", 32'h0000_0005, 32'(rx_err_ofs[0]));
        dma.rx('{0, 2'h1, 0, 0, 0}, '0);
        rdchk(IDX_RX_A_ERR, '0);
        dma.rx('{0, 2'h2, 0, 0, 0}, '{0, 0, 2'h2, 13'h1FFF, 2'h2});
        rdchk(IDX_RX_B_ERR, 32'h0000_1FFF);
        rdchk(IDX_RX_OVF_STAT, 32'h0000_0002);
        chk("rx_overrun_status", 32'h0000_0002, 32'(rx_overrun_status));
        dma.rx('{0, 2'h2, 2'h2, 13'h0007, 0}, '0);
        rdchk(IDX_RX_B_ERR, 32'h0000_0007);
        chk("rx_err_ofs b", 32'h0000_0007, 32'(rx_err_ofs[1]));
        dma.rx('{1, 0, 0, 0, 0}, '0);
        rdchk(IDX_RX_B_ERR, '0);
        rdchk(IDX_RX_OVF_STAT, '0);
        chk("rx_overrun_status", '0, 32'(rx_overrun_status));
        chk("rx_err_ofs b", '0, 32'(rx_err_ofs[1]));
    endtask
    task automatic t_irq;
        bus(IDX_IRQ_ENABLE, 1, '1);
        rdchk(IDX_IRQ_ENABLE, 32'h0000_7FFF);
        for (int k = 0; k < IRQ_W; k++) begin
            bus(IDX_IRQ_ENABLE, 1, 32'(1) << ((k + 1) % IRQ_W));
            dma.ev(15'(1) << k);
            rdchk(IDX_IRQ_PENDING, 32'(1) << k);
            chk("irq masked", '0, 32'(irq));
            bus(IDX_IRQ_ENABLE, 1, 32'(1) << k);
            repeat (2) @(posedge hclk);
            chk("irq set", 32'h0000_0001, 32'(irq));
            bus(IDX_IRQ_PENDING, 1, 32'(1) << k);
            repeat (2) @(posedge hclk);
            chk("irq clear", '0, 32'(irq));
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // whole run is well under a thousand cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_regs();
        t_err();
        t_irq();
        finish_test();
    end
endmodule
bind serial_dma_buffer_regs serial_dma_buffer_regs_assertions chk_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .rx_event(rx_event), .buf_addr(buf_addr),
    .rx_err_ofs(rx_err_ofs), .rx_overrun_status(rx_overrun_status));
